// *** logic/csd_chip_select.sv ***
// Overview of operation
// R1 - Upper region always ends at memory top.
// R2 - Upper select when address at or above base.
// R3 - Upper register resets to a 1K block.
// R4 - Software writes only legal upper encodings.
// R5 - Lower select when address at or below limit.
// R6 - Software writes only legal lower encodings.
// R7 - Lower select idle until its register accessed.
// R8 - Mid size is one-hot, one bit set.
// R9 - Mid block split into four quarters.
// R10 - Mid base taken from base register top bits.
// R11 - Software aligns mid base to block size.
// R12 - Mid selects idle until both registers accessed.
// R13 - Each region's ready bits control its waits.
// R14 - 512K mid block only at zero, lower unused.
// R15 - Enhanced mode leaves only mid select 2.
// R16 - Seven contiguous 128-byte peripheral select blocks.
// R17 - Peripheral base is a 1K multiple.
// R18 - Software zeroes top base bits in I/O.
// R19 - Peripheral ready bits split across two registers.
// R20 - Config bits choose pin function and space.
// R21 - Pins 5 and 6 may carry latched A1/A2.
// R22 - Peripheral selects idle until both registers accessed.
// R23 - Width and space bit encodings.
// R24 - Ready field: ignore bit and wait count.
// R25 - Selects high in reset; upper preset.
// R26 - Access flags arm each select group except upper.
`timescale 1ns/1ps
module csd_chip_select (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Control block register port
    input  wire logic        regSel,
    input  wire logic        regRd,
    input  wire logic        regWr,
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWdata,
    output logic      [15:0] regRdata,
    // Bus cycle address from the processor or DMA
    input  wire logic        busValid,
    input  wire logic        busIsMem,
    input  wire logic [19:0] busAddr,
    // Operating mode
    input  wire logic        enhancedMode,
    // Chip selects, active low
    output logic             upperMemSelectN,
    output logic             lowerMemSelectN,
    output logic      [3:0]  midSelectN,
    output logic      [6:0]  periphSelectN,
    // Ready control for the selected region
    output logic      [1:0]  readyWaitCount,
    output logic             readyUseExternal,
    output logic             readyRegionHit
);
    import csd_pkg::*;

    csd_cfg_if cfgBus ();

    logic [15:0] upperCtl_ff;
    logic [15:0] lowerCtl_ff;
    logic [15:0] periphBase_ff;
    logic [15:0] midBase_ff;
    logic [15:0] midCfg_ff;
    logic        lowerSeen_ff;
    logic        midBaseSeen_ff;
    logic        midCfgSeen_ff;
    logic        periphBaseSeen_ff;
    logic [15:0] regRdata_ff;
    logic [15:0] nxt_upperCtl;
    logic [15:0] nxt_lowerCtl;
    logic [15:0] nxt_periphBase;
    logic [15:0] nxt_midBase;
    logic [15:0] nxt_midCfg;
    logic        nxt_lowerSeen;
    logic        nxt_midBaseSeen;
    logic        nxt_midCfgSeen;
    logic        nxt_periphBaseSeen;
    logic [15:0] nxt_regRdata;
    logic        regAccess;
    logic        midArmed;
    logic        periphArmed;

    logic        upperSel_ff;
    logic        lowerSel_ff;
    logic [3:0]  midSel_ff;
    logic [6:0]  perSel_ff;
    logic [1:0]  waitCount_ff;
    logic        useExt_ff;
    logic        regionHit_ff;
    logic        nxt_upperSel;
    logic        nxt_lowerSel;
    logic [3:0]  nxt_midSel;
    logic [6:0]  nxt_perSel;
    logic [1:0]  nxt_waitCount;
    logic        nxt_useExt;
    logic        nxt_regionHit;

    function automatic logic isReg(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

    // Register file and access flags.
    always_comb begin
        nxt_upperCtl       = upperCtl_ff;
        nxt_lowerCtl       = lowerCtl_ff;
        nxt_periphBase     = periphBase_ff;
        nxt_midBase        = midBase_ff;
        nxt_midCfg         = midCfg_ff;
        nxt_lowerSeen      = lowerSeen_ff;
        nxt_midBaseSeen    = midBaseSeen_ff;
        nxt_midCfgSeen     = midCfgSeen_ff;
        nxt_periphBaseSeen = periphBaseSeen_ff;
        nxt_regRdata       = 16'h0000;
        regAccess          = regSel && (regRd || regWr);
        if (regSel && regWr) begin
            case (regAddr)
                OFF_UPPER_CTL:   nxt_upperCtl   = regWdata;
                OFF_LOWER_CTL:   nxt_lowerCtl   = regWdata;
                OFF_PERIPH_BASE: nxt_periphBase = regWdata;
                OFF_MID_BASE:    nxt_midBase    = regWdata;
                OFF_MID_CFG:     nxt_midCfg     = regWdata;
                default:         nxt_upperCtl   = upperCtl_ff;
            endcase
        end
        // A read arms a group just as a write does; flags only clear at reset.
        if (regAccess && isReg(regAddr, OFF_LOWER_CTL)) begin
            nxt_lowerSeen = 1'b1;                                           // [R26] [R7]
        end
        if (regAccess && isReg(regAddr, OFF_MID_BASE)) begin
            nxt_midBaseSeen = 1'b1;                                         // [R26] [R12]
        end
        if (regAccess && isReg(regAddr, OFF_MID_CFG)) begin
            nxt_midCfgSeen = 1'b1;                                          // [R26]
        end
        if (regAccess && isReg(regAddr, OFF_PERIPH_BASE)) begin
            nxt_periphBaseSeen = 1'b1;                                      // [R26] [R22]
        end
        if (regSel && regRd) begin
            case (regAddr)
                OFF_UPPER_CTL:   nxt_regRdata = upperCtl_ff;
                OFF_LOWER_CTL:   nxt_regRdata = lowerCtl_ff;
                OFF_PERIPH_BASE: nxt_regRdata = periphBase_ff;
                OFF_MID_BASE:    nxt_regRdata = midBase_ff;
                OFF_MID_CFG:     nxt_regRdata = midCfg_ff;
                default:         nxt_regRdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            upperCtl_ff       <= UPPER_CTL_RESET;                           // [R3] [R25]
            lowerCtl_ff       <= CTL_RESET;
            periphBase_ff     <= CTL_RESET;
            midBase_ff        <= CTL_RESET;
            midCfg_ff         <= CTL_RESET;
            lowerSeen_ff      <= 1'b0;
            midBaseSeen_ff    <= 1'b0;
            midCfgSeen_ff     <= 1'b0;
            periphBaseSeen_ff <= 1'b0;
            regRdata_ff       <= CTL_RESET;
        end else begin
            upperCtl_ff       <= nxt_upperCtl;
            lowerCtl_ff       <= nxt_lowerCtl;
            periphBase_ff     <= nxt_periphBase;
            midBase_ff        <= nxt_midBase;
            midCfg_ff         <= nxt_midCfg;
            lowerSeen_ff      <= nxt_lowerSeen;
            midBaseSeen_ff    <= nxt_midBaseSeen;
            midCfgSeen_ff     <= nxt_midCfgSeen;
            periphBaseSeen_ff <= nxt_periphBaseSeen;
            regRdata_ff       <= nxt_regRdata;
        end
    end

    assign midArmed    = midBaseSeen_ff && midCfgSeen_ff;                   // [R12]
    assign periphArmed = periphBaseSeen_ff && midCfgSeen_ff;                // [R22]

    assign cfgBus.upperCtl     = upperCtl_ff;
    assign cfgBus.lowerCtl     = lowerCtl_ff;
    assign cfgBus.periphBase   = periphBase_ff;
    assign cfgBus.midBase      = midBase_ff;
    assign cfgBus.midCfg       = midCfg_ff;
    assign cfgBus.lowerArmed   = lowerSeen_ff;
    assign cfgBus.midArmed     = midArmed;
    assign cfgBus.periphArmed  = periphArmed;
    assign cfgBus.enhancedMode = enhancedMode;
    assign cfgBus.valid        = busValid;
    assign cfgBus.isMem        = busIsMem;
    assign cfgBus.addr         = busAddr;

    csd_decode u_decode (
        .cfg (cfgBus.dec)
    );

    // Selects are registered, so every pin is glitch free at the cost of one cycle.
    always_comb begin
        nxt_upperSel  = cfgBus.hitVec[SEL_UPPER];
        nxt_lowerSel  = cfgBus.hitVec[SEL_LOWER];
        nxt_midSel    = cfgBus.hitVec[SEL_MID0 +: MID_COUNT];
        nxt_perSel    = cfgBus.hitVec[SEL_PER0 +: PERIPH_COUNT];
        // In narrow width the two top pins hold the last cycle's A1 and A2 (stored inverted).
        if (periphArmed && !midCfg_ff[WIDEN_BIT]) begin
            nxt_perSel[5] = busValid ? ~busAddr[1] : perSel_ff[5];          // [R21] [R23]
            nxt_perSel[6] = busValid ? ~busAddr[2] : perSel_ff[6];
        end
        nxt_waitCount = cfgBus.readyMode[1:0];                              // [R24]
        nxt_useExt    = !cfgBus.readyMode[READY_IGNORE];
        nxt_regionHit = cfgBus.anyHit;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            upperSel_ff  <= 1'b0;                                           // [R25]
            lowerSel_ff  <= 1'b0;
            midSel_ff    <= 4'h0;
            perSel_ff    <= 7'h00;
            waitCount_ff <= 2'h0;
            useExt_ff    <= 1'b0;
            regionHit_ff <= 1'b0;
        end else begin
            upperSel_ff  <= nxt_upperSel;
            lowerSel_ff  <= nxt_lowerSel;
            midSel_ff    <= nxt_midSel;
            perSel_ff    <= nxt_perSel;
            waitCount_ff <= nxt_waitCount;
            useExt_ff    <= nxt_useExt;
            regionHit_ff <= nxt_regionHit;
        end
    end

    // Flops store active-high selects so that reset to zero drives the pins high.
    assign upperMemSelectN  = ~upperSel_ff;
    assign lowerMemSelectN  = ~lowerSel_ff;
    assign midSelectN       = ~midSel_ff;
    assign periphSelectN    = ~perSel_ff;
    assign readyWaitCount   = waitCount_ff;
    assign readyUseExternal = useExt_ff;
    assign readyRegionHit   = regionHit_ff;
    assign regRdata         = regRdata_ff;

    // Helper for checking the state seen at the first edge after reset.
    logic started_ff;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            started_ff <= 1'b0;
        end else begin
            started_ff <= 1'b1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    AST_UPPER_HIT: assert property ( // [R2]
        busValid && busIsMem && busAddr >= {upperCtl_ff[15:6], 10'h000} |=> !upperMemSelectN)
        else $error("upper select missing for address above base");
    AST_UPPER_RESET: assert property ( // [R3]
        !started_ff |-> upperCtl_ff == UPPER_CTL_RESET && upperMemSelectN)
        else $error("upper control not preset after reset");
    AST_LOWER_IDLE: assert property ( // [R7]
        !lowerSeen_ff |=> lowerMemSelectN)
        else $error("lower select active before its register was accessed");
    AST_LOWER_HIT: assert property ( // [R5]
        busValid && busIsMem && lowerSeen_ff && busAddr <= {lowerCtl_ff[15:6], 10'h3ff}
        |=> !lowerMemSelectN)
        else $error("lower select missing below limit");
    AST_MID_IDLE: assert property ( // [R12]
        !(midBaseSeen_ff && midCfgSeen_ff) |=> &midSelectN)
        else $error("mid select active before both registers accessed");
    AST_MID_ENHANCED: assert property ( // [R15]
        enhancedMode |=> midSelectN[0] && midSelectN[1] && midSelectN[3])
        else $error("unavailable mid select driven in enhanced mode");
    AST_MID_ONE: assert property ( // [R9]
        $onehot0(~midSelectN))
        else $error("more than one mid select active");
    AST_PER_IDLE: assert property ( // [R22]
        !(periphBaseSeen_ff && midCfgSeen_ff) |=> &periphSelectN)
        else $error("peripheral select active before both registers accessed");
    AST_PER_ADDR: assert property ( // [R21]
        busValid && periphBaseSeen_ff && midCfgSeen_ff && !midCfg_ff[7]
        |=> periphSelectN[5] == $past(busAddr[1]) && periphSelectN[6] == $past(busAddr[2]))
        else $error("latched address bits wrong on narrow peripheral pins");
    AST_ARM_STICKY: assert property ( // [R26]
        regSel && (regRd || regWr) && regAddr == OFF_LOWER_CTL |=> lowerSeen_ff [*4])
        else $error("lower access flag not set or not held");
    AST_READY_UPPER: assert property ( // [R24]
        busValid && busIsMem && busAddr >= {upperCtl_ff[15:6], 10'h000}
        |=> readyWaitCount == $past(upperCtl_ff[1:0])
            && readyUseExternal == !$past(upperCtl_ff[2]) && readyRegionHit)
        else $error("ready control does not follow upper region bits");

    COV_UPPER: cover property (busValid && busIsMem ##1 !upperMemSelectN);
    COV_MID2_ENH: cover property (enhancedMode ##1 !midSelectN[2]);
    COV_PER6: cover property (midCfg_ff[7] ##1 !periphSelectN[6]);
    COV_LOWER: cover property (!lowerMemSelectN ##1 !lowerMemSelectN);

endmodule

// *** logic/csd_pkg.sv ***
package csd_pkg;

    // Control block offsets of the chip-select registers.
    localparam logic [7:0]  OFF_UPPER_CTL   = 8'ha0;
    localparam logic [7:0]  OFF_LOWER_CTL   = 8'ha2;
    localparam logic [7:0]  OFF_PERIPH_BASE = 8'ha4;
    localparam logic [7:0]  OFF_MID_BASE    = 8'ha6;
    localparam logic [7:0]  OFF_MID_CFG     = 8'ha8;

    // Values after reset.
    localparam logic [15:0] UPPER_CTL_RESET = 16'hfffb;
    localparam logic [15:0] CTL_RESET       = 16'h0000;

    // Field positions.
    localparam int          UPPER_LSB       = 6;
    localparam int          LOWER_LSB       = 6;
    localparam int          MID_BASE_LSB    = 9;
    localparam int          MID_SIZE_LSB    = 8;
    localparam int          MID_SIZE_MSB    = 14;
    localparam int          WIDEN_BIT       = 7;
    localparam int          SPACE_BIT       = 6;
    localparam int          PBA_LSB         = 6;
    localparam int          READY_IGNORE    = 2;
    localparam int          MID_QUARTER_LSB = 11;
    localparam int          PERIPH_IDX_LSB  = 7;

    // Address map constants.
    localparam logic [19:0] MEM_TOP         = 20'hfffff;
    localparam logic [19:0] PERIPH_SPAN     = 20'h00380;
    localparam int          PERIPH_COUNT    = 7;
    localparam int          PERIPH_NARROW   = 5;
    localparam int          MID_COUNT       = 4;
    localparam int          MID_ENH_KEEP    = 2;

    // Positions in the internal select vector.
    localparam int          SEL_UPPER       = 0;
    localparam int          SEL_LOWER       = 1;
    localparam int          SEL_MID0        = 2;
    localparam int          SEL_PER0        = 6;
    localparam int          SEL_COUNT       = 13;

endpackage

// *** logic/csd_cfg_if.sv ***
`timescale 1ns/1ps
interface csd_cfg_if;
    logic [15:0]                   upperCtl;
    logic [15:0]                   lowerCtl;
    logic [15:0]                   periphBase;
    logic [15:0]                   midBase;
    logic [15:0]                   midCfg;
    logic                          lowerArmed;
    logic                          midArmed;
    logic                          periphArmed;
    logic                          enhancedMode;
    logic                          valid;
    logic                          isMem;
    logic [19:0]                   addr;
    logic [csd_pkg::SEL_COUNT-1:0] hitVec;
    logic [2:0]                    readyMode;
    logic                          anyHit;

    modport regs (
        output upperCtl, lowerCtl, periphBase, midBase, midCfg,
        output lowerArmed, midArmed, periphArmed, enhancedMode,
        output valid, isMem, addr,
        input  hitVec, readyMode, anyHit
    );

    modport dec (
        input  upperCtl, lowerCtl, periphBase, midBase, midCfg,
        input  lowerArmed, midArmed, periphArmed, enhancedMode,
        input  valid, isMem, addr,
        output hitVec, readyMode, anyHit
    );
endinterface

// *** logic/csd_decode.sv ***
`timescale 1ns/1ps
module csd_decode (
    // Configuration in, selects out
    csd_cfg_if.dec cfg
);
    import csd_pkg::*;

    logic [19:0] upperBase;
    logic [19:0] lowerLimit;
    logic [19:0] midStart;
    logic [19:0] midSize;
    logic [19:0] midOff;
    logic [19:0] perStart;
    logic [19:0] perOff;
    logic        inMid;
    logic        inPer;
    logic [1:0]  quarter;
    logic [2:0]  perIdx;

    // The size field is one-hot; a quarter is a quarter of the total block.
    function automatic logic [1:0] midQuarter(input logic [19:0] off, input logic [6:0] size);
        logic [1:0] q;
        q = 2'h0;
        for (int k = 0; k < 7; k++) begin
            if (size[k]) begin
                q = off[MID_QUARTER_LSB + k +: 2];
            end
        end
        return q;
    endfunction

    always_comb begin
        upperBase  = {cfg.upperCtl[15:UPPER_LSB], 10'h000};                 // [R2]
        lowerLimit = {cfg.lowerCtl[15:LOWER_LSB], 10'h3ff};                 // [R5]
        midStart   = {cfg.midBase[15:MID_BASE_LSB], 13'h0000};              // [R10]
        midSize    = {cfg.midCfg[MID_SIZE_MSB:MID_SIZE_LSB], 13'h0000};     // [R8]
        midOff     = cfg.addr - midStart;
        inMid      = (cfg.addr >= midStart) && (midOff < midSize);
        quarter    = midQuarter(midOff, cfg.midCfg[MID_SIZE_MSB:MID_SIZE_LSB]);  // [R9]
        perStart   = {cfg.periphBase[15:PBA_LSB], 10'h000};                 // [R17]
        perOff     = cfg.addr - perStart;
        // Space bit high means memory cycles, low means I/O cycles.
        inPer      = (cfg.addr >= perStart) && (perOff < PERIPH_SPAN)
                     && (cfg.isMem == cfg.midCfg[SPACE_BIT]);                // [R20] [R23]
        perIdx     = perOff[PERIPH_IDX_LSB +: 3];                           // [R16]

        cfg.hitVec = '0;
        // The upper region always runs to the top of memory.
        cfg.hitVec[SEL_UPPER] = cfg.valid && cfg.isMem
                                && (cfg.addr >= upperBase) && (cfg.addr <= MEM_TOP);  // [R1]
        cfg.hitVec[SEL_LOWER] = cfg.valid && cfg.isMem && cfg.lowerArmed
                                && (cfg.addr <= lowerLimit);                // [R5] [R7]
        for (int i = 0; i < MID_COUNT; i++) begin
            cfg.hitVec[SEL_MID0 + i] = cfg.valid && cfg.isMem && cfg.midArmed && inMid
                                       && (quarter == i[1:0])
                                       && (!cfg.enhancedMode || i == MID_ENH_KEEP);  // [R15]
        end
        for (int i = 0; i < PERIPH_COUNT; i++) begin
            cfg.hitVec[SEL_PER0 + i] = cfg.valid && cfg.periphArmed && inPer
                                       && (perIdx == i[2:0])
                                       && (i < PERIPH_NARROW || cfg.midCfg[WIDEN_BIT]);  // [R22]
        end

        // Each region brings its own ready mode; the peripheral bank is split in two.
        if (cfg.hitVec[SEL_UPPER]) begin
            cfg.readyMode = cfg.upperCtl[2:0];                              // [R13]
        end else if (cfg.hitVec[SEL_LOWER]) begin
            cfg.readyMode = cfg.lowerCtl[2:0];
        end else if (|cfg.hitVec[SEL_MID0 +: MID_COUNT]) begin
            cfg.readyMode = cfg.midBase[2:0];
        end else if (|cfg.hitVec[SEL_PER0 +: 4]) begin
            cfg.readyMode = cfg.periphBase[2:0];                            // [R19]
        end else begin
            cfg.readyMode = cfg.midCfg[2:0];
        end
        cfg.anyHit = |cfg.hitVec;
    end

endmodule

// *** testbench/csd_mem_model.sv ***
`timescale 1ns/1ps
// Memory chips on the shared local data bus. Two enabled together would fight on the bus.
module csd_mem_model (
    // Memory chip enables, active low
    input  wire logic [5:0] memSelN,
    // Set while more than one memory chip is enabled
    output logic            busClash
);
    always_comb begin
        busClash = ($countones(~memSelN) > 1);
    end
endmodule

// *** testbench/tb_chip_select_decoder.sv ***
`timescale 1ns/1ps
module tb_chip_select_decoder;
    import csd_pkg::*;

    typedef struct packed {
        logic [19:0] addr;
        logic        isMem;
        logic [12:0] act;
        logic [3:0]  rdy;
    } csd_row_t;

    logic        clock;
    logic        reset_n;
    logic        regSel;
    logic        regRd;
    logic        regWr;
    logic [7:0]  regAddr;
    logic [15:0] regWdata;
    logic [15:0] regRdata;
    logic        busValid;
    logic        busIsMem;
    logic [19:0] busAddr;
    logic        enhancedMode;
    logic        upperMemSelectN;
    logic        lowerMemSelectN;
    logic [3:0]  midSelectN;
    logic [6:0]  periphSelectN;
    logic [1:0]  readyWaitCount;
    logic        readyUseExternal;
    logic        readyRegionHit;
    logic        busClash;
    logic [12:0] selN;
    int          n_errors;
    int          cmp_count;

    // Active bits: 12 upper, 11 lower, 10..7 mid 3..0, 6..0 peripheral. Ready: hit, ext, waits.
    csd_row_t rows [20] = '{
        '{20'hfffff, 1'b1, 13'h1000, 4'h8}, '{20'hfe000, 1'b1, 13'h1000, 4'h8},
        '{20'hfdfff, 1'b1, 13'h0000, 4'h0}, '{20'h007ff, 1'b1, 13'h0800, 4'hc},
        '{20'h00800, 1'b1, 13'h0000, 4'h0}, '{20'h1ffff, 1'b1, 13'h0000, 4'h0},
        '{20'h20000, 1'b1, 13'h0080, 4'hd}, '{20'h21fff, 1'b1, 13'h0080, 4'hd},
        '{20'h22000, 1'b1, 13'h0100, 4'hd}, '{20'h25fff, 1'b1, 13'h0200, 4'hd},
        '{20'h27fff, 1'b1, 13'h0400, 4'hd}, '{20'h28000, 1'b1, 13'h0000, 4'h0},
        '{20'h20000, 1'b0, 13'h0000, 4'h0}, '{20'h01000, 1'b0, 13'h0001, 4'he},
        '{20'h01080, 1'b0, 13'h0002, 4'he}, '{20'h01200, 1'b0, 13'h0010, 4'ha},
        '{20'h01300, 1'b0, 13'h0040, 4'ha}, '{20'h0137f, 1'b0, 13'h0040, 4'ha},
        '{20'h01380, 1'b0, 13'h0000, 4'h0}, '{20'h01000, 1'b1, 13'h0000, 4'h0}
    };

    assign selN = {upperMemSelectN, lowerMemSelectN, midSelectN, periphSelectN};

    csd_chip_select dut (.clock(clock), .reset_n(reset_n), .regSel(regSel), .regRd(regRd),
        .regWr(regWr), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .busValid(busValid), .busIsMem(busIsMem), .busAddr(busAddr),
        .enhancedMode(enhancedMode), .upperMemSelectN(upperMemSelectN),
        .lowerMemSelectN(lowerMemSelectN), .midSelectN(midSelectN),
        .periphSelectN(periphSelectN), .readyWaitCount(readyWaitCount),
        .readyUseExternal(readyUseExternal), .readyRegionHit(readyRegionHit));

    csd_mem_model partner (.memSelN(selN[12:7]), .busClash(busClash));

    always #25 clock = ~clock;

    task automatic report(input string name, input logic [17:0] exp, input logic [17:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
        report($sformatf("register %h", a), {2'b00, exp}, {2'b00, regRdata});
    endtask

    task automatic chk_out(input logic [19:0] a, input logic [12:0] act, input logic [3:0] rdy);
        logic [2:0] seen;
        seen = rdy[3] ? {readyUseExternal, readyWaitCount} : 3'b000;
        report($sformatf("outputs %h", a), {~act, rdy, 1'b0},
               {selN, readyRegionHit, seen, busClash});
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        regSel   <= 1'b1;
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clock);
        regSel   <= 1'b0;
        regWr    <= 1'b0;
    endtask

    // Read data is registered, so it is looked at just after the edge that takes the read.
    task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock);
        regSel  <= 1'b1;
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regSel  <= 1'b0;
        regRd   <= 1'b0;
        #1;
        chk_reg(a, exp);
    endtask

    task automatic bus(input logic [19:0] a, input logic m, input logic [12:0] act,
                       input logic [3:0] rdy);
        @(posedge clock);
        busValid <= 1'b1;
        busIsMem <= m;
        busAddr  <= a;
        @(posedge clock);
        #1;
        chk_out(a, act, rdy);
    endtask

    task automatic final_report();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        final_report();
    end

    initial begin
        clock = 1'b0;
        reset_n = 1'b0;
        {regSel, regRd, regWr, busValid, busIsMem, enhancedMode} = 6'h00;
        regAddr = 8'h00;
        regWdata = 16'h0000;
        busAddr = 20'h00000;
        n_errors = 0;
        cmp_count = 0;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        bus(20'hffff0, 1'b1, 13'h1000, 4'hf);
        bus(20'hffbff, 1'b1, 13'h0000, 4'h0);
        bus(20'h00000, 1'b1, 13'h0000, 4'h0);
        reg_read(OFF_UPPER_CTL, UPPER_CTL_RESET);
        reg_read(OFF_LOWER_CTL, CTL_RESET);
        bus(20'h00000, 1'b1, 13'h0800, 4'hc);
        reg_write(OFF_PERIPH_BASE, 16'h0102);
        bus(20'h01000, 1'b0, 13'h0000, 4'h0);
        reg_write(OFF_MID_CFG, 16'h0486);
        bus(20'h04000, 1'b1, 13'h0000, 4'h0);
        reg_write(OFF_MID_BASE, 16'h2001);
        reg_write(OFF_LOWER_CTL, 16'h0078);
        reg_write(OFF_UPPER_CTL, 16'hfe3c);
        reg_write(8'haa, 16'h1234);
        reg_read(8'haa, 16'h0000);
        reg_read(OFF_UPPER_CTL, 16'hfe3c);
        reg_read(OFF_LOWER_CTL, 16'h0078);
        reg_read(OFF_PERIPH_BASE, 16'h0102);
        reg_read(OFF_MID_BASE, 16'h2001);
        reg_read(OFF_MID_CFG, 16'h0486);
        foreach (rows[i]) begin
            bus(rows[i].addr, rows[i].isMem, rows[i].act, rows[i].rdy);
        end
        @(posedge clock);
        enhancedMode <= 1'b1;
        bus(20'h20000, 1'b1, 13'h0000, 4'h0);
        bus(20'h24000, 1'b1, 13'h0200, 4'hd);
        enhancedMode <= 1'b0;
        reg_write(OFF_MID_CFG, 16'h0446);
        bus(20'h01004, 1'b1, 13'h0021, 4'he);
        bus(20'h01282, 1'b1, 13'h0040, 4'h0);
        @(posedge clock);
        reset_n <= 1'b0;
        @(posedge clock);
        #1;
        report("outputs in reset", 18'h3ffe0, {selN, readyRegionHit, readyUseExternal,
               readyWaitCount, busClash});
        @(posedge clock);
        reset_n <= 1'b1;
        bus(20'h00000, 1'b0, 13'h0000, 4'h0);
        final_report();
    end
endmodule
